/* rst_seq_pkg.sv */
// Constants shared by both ends of the clock and reset sequencing link
package rst_seq_pkg;
  localparam int unsigned CLK_PERIOD_NS = 10;
  localparam int unsigned RESET_HOLD_NS = 1000000;
  localparam int unsigned RESET_HOLD_CYCLES =
    (RESET_HOLD_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int unsigned GUARD_NS = 300;
  localparam int unsigned GUARD_CYCLES =
    (GUARD_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam logic [7:0] BOOT_CLOCKS = 8'h0A;
  localparam logic [1:0] STROBE_EXTRA = 2'h2;
  localparam logic [7:0] SOFT_CYCLES = 8'h10;
  localparam logic [7:0] LOCK_CYCLES = 8'h20;
  localparam logic [1:0] ID_NONE = 2'h0;
  localparam logic [1:0] ID_COMPAT = 2'h1;
  localparam logic [1:0] ID_AUX = 2'h2;
  localparam logic [7:0] OFF_RESTART_CTRL = 8'h00;
  localparam logic [7:0] OFF_PCI_RESET = 8'h04;
  localparam logic [7:0] OFF_CFG_VALUES = 8'h08;
  localparam logic [7:0] OFF_STATUS = 8'h0C;
  localparam logic [7:0] OFF_PLL_TAP = 8'h10;
  localparam int unsigned BIT_HARD = 0;
  localparam int unsigned BIT_SOFT = 1;
  localparam int unsigned BIT_BIST = 2;
  localparam logic [15:0] CFG_VALUES_RESET = 16'h0000;
  localparam logic [2:0] PLL_TAP_RESET = 3'h4;
  typedef enum logic [2:0] {
    ST_POWER_OFF = 3'b000,
    ST_HOLD = 3'b001,
    ST_RUN = 3'b010,
    ST_PCI_HOLD = 3'b011,
    ST_SOFT = 3'b100
  } seq_state_type;
endpackage : rst_seq_pkg

/* bridge_link_if.sv */
// Pins between the bridge and the host bus system around it
`timescale 1ns/1ps
`default_nettype none
interface bridge_link_if;
  logic host_reset_n_o;
  logic host_reset_oe;
  logic host_reset_n;
  logic pci_clk;
  logic pci_clock_feedback;
  logic supply_stable_flag;
  logic arb_request_pin;
  logic arb_grant_pin;
  logic clock_mode_strap;
  logic ratio_select_strobe_n;
  logic soft_restart_n;
  logic pci_side_restart_n;
  logic host_bus_fatal_event_n;
  logic [15:0] host_data;
  logic host_data_oe;
  // Pulled up when nobody drives
  assign host_reset_n = host_reset_oe ? host_reset_n_o : 1'b1;
  modport dev (
    output host_reset_n_o, host_reset_oe, pci_clk, ratio_select_strobe_n,
    output soft_restart_n, pci_side_restart_n, host_data, host_data_oe,
    input host_reset_n, pci_clock_feedback, supply_stable_flag,
    input arb_request_pin, arb_grant_pin, clock_mode_strap,
    input host_bus_fatal_event_n
  );
  modport sys (
    input host_reset_n, pci_clk, ratio_select_strobe_n, soft_restart_n,
    input pci_side_restart_n, host_data, host_data_oe,
    output pci_clock_feedback, supply_stable_flag, arb_request_pin,
    output arb_grant_pin, clock_mode_strap, host_bus_fatal_event_n
  );
endinterface : bridge_link_if
`default_nettype wire

/* bridge_reset_end.sv */
// Bridge end: clock divider, identity capture and reset sequencing
//
// Function
// - Host and PCI sides kept as separate domains
// - PCI clock is host clock divided by two
// - Lock returned PCI clock copy to internal clock
// - Only derived clock mode, set by strap
// - System runs host clock ten cycles first
// - Capture identity when supply stable asserts
// - Grant high/request low compat; reverse auxiliary
// - Hard reset returns registers to defaults
// - PCI reset held at least one millisecond
// - Compat bridge drives config values during reset
// - Ratio strobe outlasts hard reset two clocks
// - All drive reset until identity; compat 1ms
// - Auxiliary releases reset pin; identity kept
// - Software hard reset from restart control
// - Software soft restart keeps registers
// - PCI reset register resets PCI only
// - Self-test: soft restart from start of hard reset, held past release
// - Host fatal event asserts PCI reset
// - Compat: PCI and host reset released together
// - Host agents sample reset-time options
// - System forces management interrupt high around host reset
// - System blocks ISA restart around fatal reset
`timescale 1ns/1ps
`default_nettype none
module bridge_reset_end #(
  parameter int unsigned RESET_HOLD_CYCLES = rst_seq_pkg::RESET_HOLD_CYCLES
) (
  input wire logic i_sys_clk,
  input wire logic i_reset_n,
  bridge_link_if.dev link,
  input wire logic [7:0] i_addr,
  input wire logic [31:0] i_wdata,
  input wire logic i_wr,
  input wire logic i_rd,
  output logic [31:0] o_rdata
);
  function automatic logic hit(input logic [7:0] a, input logic [7:0] off);
    hit = (a == off);
  endfunction : hit
  // Pin synchronisers: supply, request, grant, strap, fatal, feedback, reset
  logic [6:0] pin_meta;
  logic [6:0] pin_sync;
  always_ff @(posedge i_sys_clk) begin
    pin_meta <= {link.supply_stable_flag, link.arb_request_pin,
                 link.arb_grant_pin, link.clock_mode_strap,
                 link.host_bus_fatal_event_n, link.pci_clock_feedback,
                 link.host_reset_n};
    pin_sync <= pin_meta;
  end
  wire supply_sync = pin_sync[6];
  wire request_sync = pin_sync[5];
  wire grant_sync = pin_sync[4];
  wire strap_sync = pin_sync[3];
  wire fatal_low = ~pin_sync[2];
  wire feedback_sync = pin_sync[1];
  wire reset_pin_low = ~pin_sync[0];

  rst_seq_pkg::seq_state_type state;
  rst_seq_pkg::seq_state_type next_state;
  logic [31:0] cnt;
  logic [31:0] next_cnt;
  logic supply_prev;
  logic [1:0] identity;
  logic bist_pending;
  logic pci_reset_reg;
  logic [15:0] cfg_values;
  logic [2:0] pll_tap;
  logic [7:0] pci_hist;
  logic [7:0] lock_cnt;
  logic [1:0] strobe_cnt;
  logic pci_clk;
  logic reset_drive;
  logic strobe;
  logic soft_restart;
  logic pci_reset;
  logic data_oe;

  wire supply_rise = supply_sync & ~supply_prev;
  wire is_compat = (identity == rst_seq_pkg::ID_COMPAT);
  wire [31:0] hold_last = 32'(RESET_HOLD_CYCLES - 1);
  wire [31:0] soft_last = {24'h00_0000, rst_seq_pkg::SOFT_CYCLES} - 32'h1;
  wire regs_clear = ~i_reset_n | reset_pin_low;
  wire wr_ctrl = i_wr & hit(i_addr, rst_seq_pkg::OFF_RESTART_CTRL);
  wire wr_pci = i_wr & hit(i_addr, rst_seq_pkg::OFF_PCI_RESET);
  wire wr_cfg = i_wr & hit(i_addr, rst_seq_pkg::OFF_CFG_VALUES);
  wire wr_tap = i_wr & hit(i_addr, rst_seq_pkg::OFF_PLL_TAP);
  wire req_hard = wr_ctrl & i_wdata[rst_seq_pkg::BIT_HARD] & is_compat;
  wire req_soft = wr_ctrl & i_wdata[rst_seq_pkg::BIT_SOFT] & is_compat;
  wire req_bist = wr_ctrl & i_wdata[rst_seq_pkg::BIT_BIST] & is_compat;
  wire locked = (lock_cnt == rst_seq_pkg::LOCK_CYCLES);
  wire mode_ok = strap_sync;
  // Sequencer
  always_comb begin
    next_state = state;
    next_cnt = cnt + 32'h1;
    case (state)
      rst_seq_pkg::ST_POWER_OFF: begin
        next_cnt = 32'h0;
        if (supply_rise) begin
          next_state = rst_seq_pkg::ST_HOLD;
        end
      end
      rst_seq_pkg::ST_HOLD: begin
        if (cnt >= hold_last) begin
          next_cnt = 32'h0;
          next_state = bist_pending ? rst_seq_pkg::ST_SOFT
                                    : rst_seq_pkg::ST_RUN;
        end
      end
      rst_seq_pkg::ST_RUN: begin
        next_cnt = 32'h0;
        if (req_hard | req_bist) begin
          next_state = rst_seq_pkg::ST_HOLD;
        end else if (req_soft) begin
          next_state = rst_seq_pkg::ST_SOFT;
        end else if (fatal_low) begin
          next_state = rst_seq_pkg::ST_PCI_HOLD;
        end
      end
      rst_seq_pkg::ST_PCI_HOLD: begin
        if (cnt >= hold_last) begin
          next_cnt = 32'h0;
          next_state = rst_seq_pkg::ST_RUN;
        end
      end
      rst_seq_pkg::ST_SOFT: begin
        if (cnt >= soft_last) begin
          next_cnt = 32'h0;
          next_state = rst_seq_pkg::ST_RUN;
        end
      end
      default: begin
        next_cnt = 32'h0;
        next_state = rst_seq_pkg::ST_POWER_OFF;
      end
    endcase
    if (!supply_sync) begin
      next_cnt = 32'h0;
      next_state = rst_seq_pkg::ST_POWER_OFF;
    end
  end
  // Output decode from next state
  wire next_power_off = (next_state == rst_seq_pkg::ST_POWER_OFF);
  wire next_hold = (next_state == rst_seq_pkg::ST_HOLD);
  wire next_compat = supply_rise
    ? (grant_sync & ~request_sync) : is_compat;
  wire next_reset_drive = next_power_off | (next_hold & next_compat);
  wire next_strobe = next_reset_drive | (strobe_cnt != 2'h0);
  wire next_soft_restart = (next_state == rst_seq_pkg::ST_SOFT)
    | (next_hold & (bist_pending | req_bist));
  wire next_pci_reset = next_power_off | next_hold | fatal_low
    | (next_state == rst_seq_pkg::ST_PCI_HOLD) | pci_reset_reg;
  wire next_data_oe = next_hold & next_compat;

  always_ff @(posedge i_sys_clk) begin
    if (!i_reset_n) begin
      state <= rst_seq_pkg::ST_POWER_OFF;
      cnt <= 32'h0;
      supply_prev <= 1'b0;
      bist_pending <= 1'b0;
    end else begin
      state <= next_state;
      cnt <= next_cnt;
      supply_prev <= supply_sync;
      if (req_bist && state == rst_seq_pkg::ST_RUN) begin
        bist_pending <= 1'b1;
      end else if (next_state != rst_seq_pkg::ST_HOLD) begin
        bist_pending <= 1'b0;
      end
    end
  end

  // Identity taken only at the supply edge
  always_ff @(posedge i_sys_clk) begin
    if (!i_reset_n) begin
      identity <= rst_seq_pkg::ID_NONE;
    end else if (supply_rise) begin
      if (grant_sync && !request_sync) begin
        identity <= rst_seq_pkg::ID_COMPAT;
      end else if (!grant_sync && request_sync) begin
        identity <= rst_seq_pkg::ID_AUX;
      end else begin
        identity <= rst_seq_pkg::ID_NONE;
      end
    end
  end

  // Software registers, cleared by any hard reset
  always_ff @(posedge i_sys_clk) begin
    if (regs_clear) begin
      pci_reset_reg <= 1'b0;
      cfg_values <= rst_seq_pkg::CFG_VALUES_RESET;
      pll_tap <= rst_seq_pkg::PLL_TAP_RESET;
    end else begin
      if (wr_pci) begin
        pci_reset_reg <= i_wdata[0];
      end
      if (wr_cfg) begin
        cfg_values <= i_wdata[15:0];
      end
      if (wr_tap) begin
        pll_tap <= i_wdata[2:0];
      end
    end
  end

  // Divider and phase detector on the returned copy
  always_ff @(posedge i_sys_clk) begin
    if (!i_reset_n) begin
      pci_clk <= 1'b0;
      pci_hist <= 8'h00;
      lock_cnt <= 8'h00;
    end else begin
      pci_clk <= ~pci_clk;
      pci_hist <= {pci_hist[6:0], pci_clk};
      if (feedback_sync != pci_hist[pll_tap] || !mode_ok) begin
        lock_cnt <= 8'h00;
      end else if (!locked) begin
        lock_cnt <= lock_cnt + 8'h01;
      end
    end
  end

  // Pin drivers
  always_ff @(posedge i_sys_clk) begin
    if (!i_reset_n) begin
      reset_drive <= 1'b1;
      strobe <= 1'b1;
      strobe_cnt <= 2'h0;
      soft_restart <= 1'b0;
      pci_reset <= 1'b1;
      data_oe <= 1'b0;
    end else begin
      reset_drive <= next_reset_drive;
      strobe <= next_strobe;
      strobe_cnt <= next_reset_drive ? rst_seq_pkg::STROBE_EXTRA
        : ((strobe_cnt != 2'h0) ? strobe_cnt - 2'h1 : 2'h0);
      soft_restart <= next_soft_restart;
      pci_reset <= next_pci_reset;
      data_oe <= next_data_oe;
    end
  end

  assign link.host_reset_n_o = 1'b0;
  assign link.host_reset_oe = reset_drive;
  assign link.pci_clk = pci_clk;
  assign link.ratio_select_strobe_n = ~strobe;
  assign link.soft_restart_n = ~soft_restart;
  assign link.pci_side_restart_n = ~pci_reset;
  assign link.host_data = cfg_values;
  assign link.host_data_oe = data_oe;

  // Read port
  wire [31:0] status_word = {20'h0_0000, lock_cnt[7:7], 3'h0, identity,
    locked, mode_ok, 1'b0, state};
  wire [31:0] read_mux =
    hit(i_addr, rst_seq_pkg::OFF_PCI_RESET) ? {31'h0, pci_reset_reg}
    : hit(i_addr, rst_seq_pkg::OFF_CFG_VALUES) ? {16'h0000, cfg_values}
    : hit(i_addr, rst_seq_pkg::OFF_STATUS) ? status_word
    : hit(i_addr, rst_seq_pkg::OFF_PLL_TAP) ? {29'h0, pll_tap}
    : 32'h0000_0000;
  always_ff @(posedge i_sys_clk) begin
    if (!i_reset_n) begin
      o_rdata <= 32'h0000_0000;
    end else begin
      o_rdata <= i_rd ? read_mux : 32'h0000_0000;
    end
  end
endmodule : bridge_reset_end
`default_nettype wire

/* host_system_end.sv */
// System end: power-good, straps, clock buffer and signal blocking
`timescale 1ns/1ps
`default_nettype none
module host_system_end (
  input wire logic i_sys_clk,
  input wire logic i_reset_n,
  bridge_link_if.sys link,
  input wire logic i_power_ok,
  input wire logic i_primary,
  input wire logic i_fatal_event,
  input wire logic i_isa_smi_n,
  input wire logic i_isa_cpu_restart_n,
  output logic o_cpu_smi_n,
  output logic o_cpu_restart_n,
  output logic [15:0] o_cfg_options,
  output logic o_cfg_valid,
  output logic o_host_reset_n
);
  // Pin synchronisers: reset, pci reset, pci clock, data enable, data
  logic [19:0] pin_meta;
  logic [19:0] pin_sync;
  // Board inputs: power, fatal event, ISA interrupt and restart
  logic [3:0] in_meta;
  logic [3:0] in_sync;
  always_ff @(posedge i_sys_clk) begin
    pin_meta <= {link.host_reset_n, link.pci_side_restart_n, link.pci_clk,
                 link.host_data_oe, link.host_data};
    pin_sync <= pin_meta;
    in_meta <= {i_power_ok, i_fatal_event, i_isa_smi_n, i_isa_cpu_restart_n};
    in_sync <= in_meta;
  end
  wire power_ok = in_sync[3];
  wire fatal_event = in_sync[2];
  wire isa_smi_n = in_sync[1];
  wire isa_cpu_restart_n = in_sync[0];
  wire reset_low = ~pin_sync[19];
  wire pci_low = ~pin_sync[18];

  logic [7:0] boot_cnt;
  logic supply;
  logic feedback;
  logic fatal_n;
  logic [7:0] smi_guard;
  logic [7:0] rst_guard;
  logic fatal_flag;
  wire [7:0] guard = 8'(rst_seq_pkg::GUARD_CYCLES);

  always_ff @(posedge i_sys_clk) begin
    if (!i_reset_n) begin
      boot_cnt <= 8'h00;
      supply <= 1'b0;
      feedback <= 1'b0;
      fatal_n <= 1'b1;
    end else begin
      if (!power_ok) begin
        boot_cnt <= 8'h00;
      end else if (boot_cnt != rst_seq_pkg::BOOT_CLOCKS) begin
        boot_cnt <= boot_cnt + 8'h01;
      end
      supply <= power_ok && boot_cnt == rst_seq_pkg::BOOT_CLOCKS;
      feedback <= pin_sync[17];
      fatal_n <= ~fatal_event;
    end
  end

  assign link.supply_stable_flag = supply;
  assign link.arb_grant_pin = i_primary;
  assign link.arb_request_pin = ~i_primary;
  assign link.clock_mode_strap = 1'b1;
  assign link.pci_clock_feedback = feedback;
  assign link.host_bus_fatal_event_n = fatal_n;

  // Option capture, interrupt forcing and restart blocking
  always_ff @(posedge i_sys_clk) begin
    if (!i_reset_n) begin
      o_cfg_options <= 16'h0000;
      o_cfg_valid <= 1'b0;
      o_host_reset_n <= 1'b0;
      smi_guard <= 8'h00;
      rst_guard <= 8'h00;
      fatal_flag <= 1'b0;
      o_cpu_smi_n <= 1'b1;
      o_cpu_restart_n <= 1'b1;
    end else begin
      o_host_reset_n <= ~reset_low;
      if (reset_low) begin
        o_cfg_valid <= 1'b0;
        if (pin_sync[16]) begin
          o_cfg_options <= pin_sync[15:0];
        end
      end else begin
        o_cfg_valid <= 1'b1;
      end
      smi_guard <= reset_low ? guard
        : ((smi_guard != 8'h00) ? smi_guard - 8'h01 : 8'h00);
      o_cpu_smi_n <= (reset_low || smi_guard != 8'h00) ? 1'b1
        : isa_smi_n;
      if (!fatal_n) begin
        fatal_flag <= 1'b1;
      end else if (!pci_low && rst_guard == 8'h00) begin
        fatal_flag <= 1'b0;
      end
      rst_guard <= pci_low ? guard
        : ((rst_guard != 8'h00) ? rst_guard - 8'h01 : 8'h00);
      o_cpu_restart_n <= (fatal_flag && (pci_low || rst_guard != 8'h00))
        ? 1'b1 : isa_cpu_restart_n;
    end
  end
endmodule : host_system_end
`default_nettype wire

/* bridge_link_chk.sv */
// Checker for the pins between the bridge and system ends
`timescale 1ns/1ps
`default_nettype none
module bridge_link_chk #(
  parameter int unsigned RESET_HOLD_CYCLES = rst_seq_pkg::RESET_HOLD_CYCLES
) (
  input wire logic i_sys_clk,
  input wire logic i_reset_n,
  input wire logic host_reset_n,
  input wire logic pci_clk,
  input wire logic supply_stable_flag,
  input wire logic ratio_select_strobe_n,
  input wire logic soft_restart_n,
  input wire logic pci_side_restart_n,
  input wire logic host_bus_fatal_event_n,
  input wire logic host_data_oe
);
  logic [31:0] low_cnt;
  logic [7:0] soft_cnt;
  default clocking cb @(posedge i_sys_clk); endclocking
  default disable iff (!i_reset_n);
  // Host reset low time and soft restart length
  always_ff @(posedge i_sys_clk) begin
    low_cnt <= (host_reset_n || !supply_stable_flag) ? 32'h0 : low_cnt + 32'h1;
    soft_cnt <= (soft_restart_n || !host_reset_n) ? 8'h00 : soft_cnt + 8'h01;
  end
  sequence s_compat_release;
    $rose(host_reset_n) && $past(host_data_oe);
  endsequence
  sequence s_strobe_tail;
    !ratio_select_strobe_n ##1 !ratio_select_strobe_n ##1 ratio_select_strobe_n;
  endsequence
  property p_pci_clk_div;
    $past(i_reset_n) |-> pci_clk != $past(pci_clk);
  endproperty
  property p_strobe_tail;
    s_compat_release |-> s_strobe_tail;
  endproperty
  property p_reset_together;
    s_compat_release |-> $rose(pci_side_restart_n);
  endproperty
  property p_hold_min;
    s_compat_release |-> low_cnt >= RESET_HOLD_CYCLES &&
      low_cnt <= RESET_HOLD_CYCLES + 8;
  endproperty
  property p_fatal_pci;
    $fell(host_bus_fatal_event_n) |-> ##[1:4] !pci_side_restart_n;
  endproperty
  property p_data_drive;
    host_data_oe |-> !host_reset_n;
  endproperty
  property p_soft_len;
    $rose(soft_restart_n) |-> soft_cnt >= 8'h0F && soft_cnt <= 8'h11;
  endproperty
  property p_pci_only;
    $fell(pci_side_restart_n) && host_reset_n |=> host_reset_n [*8];
  endproperty
  a_pci_clk_div: assert property (p_pci_clk_div)
    else $error("pci clock not toggling");
  a_strobe_tail: assert property (p_strobe_tail)
    else $error("ratio strobe tail wrong");
  a_reset_together: assert property (p_reset_together)
    else $error("resets not released together");
  a_hold_min: assert property (p_hold_min)
    else $error("host reset hold length wrong");
  a_fatal_pci: assert property (p_fatal_pci)
    else $error("fatal event gave no pci reset");
  a_data_drive: assert property (p_data_drive)
    else $error("data driven outside reset");
  a_soft_len: assert property (p_soft_len)
    else $error("soft restart length wrong");
  a_pci_only: assert property (p_pci_only)
    else $error("pci reset disturbed host reset");
endmodule : bridge_link_chk
`default_nettype wire

/* tb_top.sv */
// Bench for the bridge and system ends joined by their link
`timescale 1ns/1ps
`default_nettype none
module tb_top;
  localparam int unsigned HOLD = 50;
  localparam int HR = 0;
  localparam int PR = 1;
  localparam int SR = 2;
  localparam int SUP = 3;
  logic i_sys_clk = 1'b0;
  logic i_reset_n = 1'b0;
  logic [7:0] i_addr = 8'h00;
  logic [31:0] i_wdata = 32'h0000_0000;
  logic i_wr = 1'b0;
  logic i_rd = 1'b0;
  logic i_power_ok = 1'b0;
  logic i_primary = 1'b1;
  logic i_fatal_event = 1'b0;
  logic i_isa_smi_n = 1'b1;
  logic i_isa_cpu_restart_n = 1'b1;
  logic [31:0] rdata;
  logic [31:0] r;
  logic smi_n;
  logic restart_n;
  logic cfg_valid;
  logic [15:0] cfg_options;
  logic host_reset_view;
  int waited;
  int miscompares = 0;
  int checked = 0;
  bridge_link_if link ();
  always #5 i_sys_clk = ~i_sys_clk;
  bridge_reset_end #(.RESET_HOLD_CYCLES(HOLD)) u_bridge_reset_end (
    .i_sys_clk(i_sys_clk), .i_reset_n(i_reset_n), .link(link),
    .i_addr(i_addr), .i_wdata(i_wdata), .i_wr(i_wr), .i_rd(i_rd),
    .o_rdata(rdata));
  host_system_end u_host_system_end (
    .i_sys_clk(i_sys_clk), .i_reset_n(i_reset_n), .link(link),
    .i_power_ok(i_power_ok), .i_primary(i_primary),
    .i_fatal_event(i_fatal_event), .i_isa_smi_n(i_isa_smi_n),
    .i_isa_cpu_restart_n(i_isa_cpu_restart_n), .o_cpu_smi_n(smi_n),
    .o_cpu_restart_n(restart_n), .o_cfg_options(cfg_options),
    .o_cfg_valid(cfg_valid), .o_host_reset_n(host_reset_view));
  bridge_link_chk #(.RESET_HOLD_CYCLES(HOLD)) u_bridge_link_chk (
    .i_sys_clk(i_sys_clk), .i_reset_n(i_reset_n),
    .host_reset_n(link.host_reset_n), .pci_clk(link.pci_clk),
    .supply_stable_flag(link.supply_stable_flag),
    .ratio_select_strobe_n(link.ratio_select_strobe_n),
    .soft_restart_n(link.soft_restart_n),
    .pci_side_restart_n(link.pci_side_restart_n),
    .host_bus_fatal_event_n(link.host_bus_fatal_event_n),
    .host_data_oe(link.host_data_oe));
  task automatic check(input logic [31:0] got, input logic [31:0] exp);
    checked++;
    if (got !== exp) begin
      miscompares++;
      $display("mismatch at %0t got %h exp %h", $time, got, exp);
    end
  endtask : check
  task automatic tick(input int n);
    repeat (n) @(posedge i_sys_clk);
  endtask : tick
  task automatic reg_wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge i_sys_clk);
    i_addr <= a;
    i_wdata <= d;
    i_wr <= 1'b1;
    @(posedge i_sys_clk);
    i_wr <= 1'b0;
  endtask : reg_wr
  task automatic reg_rd(input logic [7:0] a);
    @(posedge i_sys_clk);
    i_addr <= a;
    i_rd <= 1'b1;
    @(posedge i_sys_clk);
    i_rd <= 1'b0;
    #1 r = rdata;
  endtask : reg_rd
  function automatic logic pin(input int s);
    case (s)
      HR: return link.host_reset_n;
      PR: return link.pci_side_restart_n;
      SR: return link.soft_restart_n;
      default: return link.supply_stable_flag;
    endcase
  endfunction : pin
  // Bounded wait for a link pin to reach a level
  task automatic wait_pin(input int s, input logic v, input int lim);
    waited = 0;
    while (pin(s) !== v && waited < lim) begin
      @(posedge i_sys_clk);
      #1 waited++;
    end
    check({31'h0, pin(s)}, {31'h0, v});
  endtask : wait_pin
  task automatic do_reset(input logic prim);
    @(posedge i_sys_clk);
    i_reset_n <= 1'b0;
    i_power_ok <= 1'b0;
    i_primary <= prim;
    tick(5);
    i_reset_n <= 1'b1;
    tick(2);
    i_power_ok <= 1'b1;
    wait_pin(SUP, 1'b1, 40);
  endtask : do_reset
  task automatic power_up;
    i_isa_smi_n <= 1'b0;
    do_reset(1'b1);
    tick(4);
    #1 check({31'h0, link.host_reset_n}, 32'h0);
    check({16'h0, link.host_data}, 32'(rst_seq_pkg::CFG_VALUES_RESET));
    wait_pin(HR, 1'b1, HOLD + 20);
    check({31'h0, waited >= HOLD - 6}, 32'h1);
    check({31'h0, link.pci_side_restart_n}, 32'h1);
    check({31'h0, link.ratio_select_strobe_n}, 32'h0);
    check({31'h0, smi_n}, 32'h1);
    tick(2);
    i_isa_smi_n <= 1'b1;
    #1 check({31'h0, link.ratio_select_strobe_n}, 32'h1);
    check({31'h0, smi_n}, 32'h1);
    tick(40);
    #1 check({31'h0, cfg_valid}, 32'h1);
    check({31'h0, host_reset_view}, 32'h1);
    reg_rd(rst_seq_pkg::OFF_STATUS);
    check({24'h0, r[7:4], 1'b0, r[2:0]},
      {24'h0, rst_seq_pkg::ID_COMPAT, 2'h3, 1'b0, rst_seq_pkg::ST_RUN});
  endtask : power_up
  task automatic sw_hard;
    reg_wr(rst_seq_pkg::OFF_CFG_VALUES, 32'h0000_5a3c);
    reg_rd(rst_seq_pkg::OFF_CFG_VALUES);
    check(r, 32'h0000_5a3c);
    reg_rd(8'h20);
    check(r, 32'h0000_0000);
    reg_rd(rst_seq_pkg::OFF_RESTART_CTRL);
    check(r, 32'h0000_0000);
    reg_wr(rst_seq_pkg::OFF_RESTART_CTRL, 32'h1 << rst_seq_pkg::BIT_HARD);
    wait_pin(HR, 1'b0, 10);
    wait_pin(HR, 1'b1, HOLD + 20);
    reg_rd(rst_seq_pkg::OFF_CFG_VALUES);
    check(r, 32'(rst_seq_pkg::CFG_VALUES_RESET));
    check({16'h0, cfg_options}, 32'(rst_seq_pkg::CFG_VALUES_RESET));
  endtask : sw_hard
  task automatic soft_and_pci;
    reg_wr(rst_seq_pkg::OFF_CFG_VALUES, 32'h0000_1234);
    reg_wr(rst_seq_pkg::OFF_RESTART_CTRL, 32'h1 << rst_seq_pkg::BIT_SOFT);
    wait_pin(SR, 1'b0, 10);
    check({31'h0, link.host_reset_n}, 32'h1);
    wait_pin(SR, 1'b1, 40);
    reg_wr(rst_seq_pkg::OFF_PCI_RESET, 32'h0000_0001);
    wait_pin(PR, 1'b0, 5);
    tick(20);
    #1 check({31'h0, link.host_reset_n}, 32'h1);
    reg_rd(rst_seq_pkg::OFF_PCI_RESET);
    check(r, 32'h0000_0001);
    reg_rd(rst_seq_pkg::OFF_CFG_VALUES);
    check(r, 32'h0000_1234);
    reg_wr(rst_seq_pkg::OFF_PCI_RESET, 32'h0000_0000);
    wait_pin(PR, 1'b1, 5);
  endtask : soft_and_pci
  task automatic fatal_and_bist;
    @(posedge i_sys_clk);
    i_fatal_event <= 1'b1;
    i_isa_cpu_restart_n <= 1'b0;
    tick(2);
    i_fatal_event <= 1'b0;
    wait_pin(PR, 1'b0, 10);
    check({31'h0, link.host_reset_n}, 32'h1);
    wait_pin(PR, 1'b1, HOLD + 20);
    check({31'h0, restart_n}, 32'h1);
    tick(20);
    i_isa_cpu_restart_n <= 1'b1;
    #1 check({31'h0, restart_n}, 32'h1);
    reg_wr(rst_seq_pkg::OFF_RESTART_CTRL, 32'h1 << rst_seq_pkg::BIT_BIST);
    wait_pin(HR, 1'b0, 10);
    wait_pin(HR, 1'b1, HOLD + 20);
    check({31'h0, link.soft_restart_n}, 32'h0);
    wait_pin(SR, 1'b1, 40);
  endtask : fatal_and_bist
  task automatic aux_id;
    do_reset(1'b0);
    wait_pin(HR, 1'b1, 10);
    @(posedge i_sys_clk);
    i_primary <= 1'b1;
    tick(3);
    #1 check({31'h0, link.host_data_oe}, 32'h0);
    reg_rd(rst_seq_pkg::OFF_STATUS);
    check({30'h0, r[7:6]}, {30'h0, rst_seq_pkg::ID_AUX});
  endtask : aux_id
  task automatic tally_and_finish;
    if (miscompares == 0 && checked > 0) begin
      $display("All checks passed");
    end else begin
      $display("Checks failed");
    end
    $finish;
  endtask : tally_and_finish
  initial begin
    power_up();
    sw_hard();
    soft_and_pci();
    fatal_and_bist();
    aux_id();
    tally_and_finish();
  end
  initial begin
    #100000;
    miscompares++;
    tally_and_finish();
  end
endmodule : tb_top
`default_nettype wire
